/* File: logic/rtc_map.svh */
// Register offsets, field positions, reset values and timing counts of the real-time counter.
// Assumes an 8-bit register port and a 32.768 kHz low-frequency clock.
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RTC_ADDR_W          3
`define RTC_OFS_CONTROL     3'h0
`define RTC_OFS_STATUS      3'h1
`define RTC_OFS_MASK        3'h2
`define RTC_OFS_COUNT_LO    3'h3
`define RTC_OFS_COUNT_HI    3'h4

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define RTC_DATA_W          8
`define RTC_RUN_BIT         0
`define RTC_SEL_LSB         1
`define RTC_SEL_MSB         2
`define RTC_EVT_BIT         0
`define RTC_CONTROL_RESET   8'h00
`define RTC_STATUS_RESET    8'h00
`define RTC_MASK_RESET      8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define RTC_LF_HZ           32768
`define RTC_PERIOD0_MS      500
`define RTC_PERIOD1_MS      250
`define RTC_PERIOD2_MS      125
`define RTC_PERIOD3_US      62500
`define RTC_CNT_W           14
`define RTC_TERM0           (`RTC_LF_HZ * `RTC_PERIOD0_MS / 1000 - 1)
`define RTC_TERM1           (`RTC_LF_HZ * `RTC_PERIOD1_MS / 1000 - 1)
`define RTC_TERM2           (`RTC_LF_HZ * `RTC_PERIOD2_MS / 1000 - 1)
`define RTC_TERM3           (`RTC_LF_HZ * `RTC_PERIOD3_US / 1000000 - 1)
`define RTC_SYNC_STAGES     2

`endif

/* File: logic/rtc_pkg.sv */
// Types shared by the real-time counter design files.
// Assumes rtc_map.svh is on the include path.
`include "rtc_map.svh"

package rtc_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [`RTC_DATA_W-1:0] rtc_data_t;
  typedef logic [`RTC_ADDR_W-1:0] rtc_addr_t;
  typedef logic [`RTC_CNT_W-1:0]  rtc_count_t;
  typedef logic [1:0]             rtc_sel_t;

  typedef enum logic [1:0] {
    RTC_IDLE,
    RTC_RUN,
    RTC_HALT
  } rtc_state_e;

endpackage : rtc_pkg

/* File: logic/rtc_sync.sv */
// Two-stage synchroniser for levels arriving from outside the system clock.
// Assumes the inputs are slow levels; only the last stage may be read.
`timescale 1ns/10ps

module rtc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------
  // Stages
  // ----------------------------------------
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : rtc_sync

/* File: logic/rtc_counter.sv */
// Binary up-counter with synchronous clear that wins over increment.
// Assumes clear and increment come from logic on the same clock.
`timescale 1ns/10ps

module rtc_counter #(
  parameter int WIDTH = 14
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clear,
  input  wire logic             inc,
  output logic      [WIDTH-1:0] count
);

  // ----------------------------------------
  // Count register
  // ----------------------------------------
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (clear) begin
      count_d = '0;
    end else if (inc) begin
      count_d = count_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule : rtc_counter

/* File: logic/rtc_top.sv */
// Real-time counter: periodic interrupt from the low-frequency clock, register port, sticky event status.
// Assumes the low-frequency clock and debug break arrive as pins; oscillator enable and
// power-state levels come from logic on SYS_CLK.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "rtc_map.svh"

// Summary of operation
// - Periodic interrupt at four selectable intervals
// - Counter works while low-frequency oscillator runs, outside stop and deep sleep
// - Oscillator off stops and clears control and count; status and mask kept
// - Stop or deep sleep clears control and count; status and mask kept
// - Control bits 7 to 3 carry nothing
// - Debug break freezes count, keeps control
// - Count low-frequency ticks once run set
// - Period end raises interrupt, clears counter
// - Counting continues after each period end
module rtc_top (
  input  wire logic              SYS_CLK,
  input  wire logic              RESET_N,
  input  wire rtc_pkg::rtc_addr_t REG_ADDR,
  input  wire rtc_pkg::rtc_data_t REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output rtc_pkg::rtc_data_t     REG_RDATA,
  input  wire logic              LF_CLK,
  input  wire logic              LF_OSC_ENABLE,
  input  wire logic              STOP_MODE,
  input  wire logic              DEEP_SLEEP_STATE,
  input  wire logic              DEBUG_BREAK,
  output logic                   RTC_RUNNING,
  output logic                   RTC_PERIOD_INTERRUPT
);

  import rtc_pkg::*;

  // ----------------------------------------
  // Period terminal counts
  // ----------------------------------------
  localparam rtc_count_t TERM0 = rtc_count_t'(`RTC_TERM0);
  localparam rtc_count_t TERM1 = rtc_count_t'(`RTC_TERM1);
  localparam rtc_count_t TERM2 = rtc_count_t'(`RTC_TERM2);
  localparam rtc_count_t TERM3 = rtc_count_t'(`RTC_TERM3);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0]  pin_sync;
  logic        lf_level;
  logic        brk_level;
  logic        lf_prev_q;
  logic        lf_prev_d;
  logic        lf_tick;

  logic        run_q;
  logic        run_d;
  rtc_sel_t    sel_q;
  rtc_sel_t    sel_d;
  rtc_state_e  state_q;
  rtc_state_e  state_d;
  logic        shutdown;

  rtc_count_t  count;
  rtc_count_t  term;
  logic        period_end;
  logic        cnt_clear;
  logic        cnt_inc;

  logic        evt_q;
  logic        evt_d;
  logic        mask_q;
  logic        mask_d;

  rtc_data_t   rdata_q;
  rtc_data_t   rdata_d;

  logic        wr_control;
  logic        wr_status;
  logic        wr_mask;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  rtc_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk      (SYS_CLK),
    .reset_n  (RESET_N),
    .async_in ({DEBUG_BREAK, LF_CLK}),
    .sync_out (pin_sync)
  );

  assign lf_level  = pin_sync[0];
  assign brk_level = pin_sync[1];

  // ----------------------------------------
  // Low-frequency tick
  // ----------------------------------------
  // Edge taken from the second stage only, so metastability never reaches the detector
  always_comb begin
    lf_prev_d = lf_level;
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lf_prev_q <= 1'b0;
    end else begin
      lf_prev_q <= lf_prev_d;
    end
  end

  assign lf_tick = lf_level & ~lf_prev_q;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  assign wr_control = REG_WR && (REG_ADDR == `RTC_OFS_CONTROL);
  assign wr_status  = REG_WR && (REG_ADDR == `RTC_OFS_STATUS);
  assign wr_mask    = REG_WR && (REG_ADDR == `RTC_OFS_MASK);

  // ----------------------------------------
  // Power-state shutdown
  // ----------------------------------------
  // Control and count held clear whenever the oscillator is off or in stop or deep sleep, so stale run settings never survive a wake-up
  assign shutdown = ~LF_OSC_ENABLE | STOP_MODE | DEEP_SLEEP_STATE;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_comb begin
    run_d = run_q;
    sel_d = sel_q;
    if (shutdown) begin
      run_d = 1'b0;
      sel_d = '0;
    end else if (wr_control) begin
      // Writes go through even during a debug break; only counting freezes
      run_d = REG_WDATA[`RTC_RUN_BIT];
      sel_d = REG_WDATA[`RTC_SEL_MSB:`RTC_SEL_LSB];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      run_q <= 1'b0;
      sel_q <= '0;
    end else begin
      run_q <= run_d;
      sel_q <= sel_d;
    end
  end

  // ----------------------------------------
  // Run state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      RTC_IDLE: begin
        if (run_q && !shutdown) begin
          state_d = brk_level ? RTC_HALT : RTC_RUN;
        end
      end
      RTC_RUN: begin
        if (!run_q || shutdown) begin
          state_d = RTC_IDLE;
        end else if (brk_level) begin
          state_d = RTC_HALT;
        end
      end
      RTC_HALT: begin
        if (!run_q || shutdown) begin
          state_d = RTC_IDLE;
        end else if (!brk_level) begin
          state_d = RTC_RUN;
        end
      end
      default: begin
        state_d = RTC_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= RTC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign RTC_RUNNING = (state_q != RTC_IDLE);

  // ----------------------------------------
  // Period selection
  // ----------------------------------------
  // Select is read live; software keeps it steady while running
  always_comb begin
    case (sel_q)
      2'h0: term = TERM0;
      2'h1: term = TERM1;
      2'h2: term = TERM2;
      2'h3: term = TERM3;
      default: term = TERM0;
    endcase
  end

  // ----------------------------------------
  // Binary counter
  // ----------------------------------------
  assign cnt_inc    = (state_q == RTC_RUN) && run_q && !shutdown && lf_tick;
  assign period_end = cnt_inc && (count >= term);
  // Held clear whenever run is off or shut down, restart always begins from zero
  assign cnt_clear  = period_end || !run_q || shutdown;

  rtc_counter #(
    .WIDTH (`RTC_CNT_W)
  ) u_counter (
    .clk     (SYS_CLK),
    .reset_n (RESET_N),
    .clear   (cnt_clear),
    .inc     (cnt_inc),
    .count   (count)
  );

  // ----------------------------------------
  // Event status and mask
  // ----------------------------------------
  always_comb begin
    evt_d  = evt_q;
    mask_d = mask_q;
    if (wr_status && REG_WDATA[`RTC_EVT_BIT]) begin
      evt_d = 1'b0;
    end
    // Set after clear so a coinciding period end is not lost
    if (period_end) begin
      evt_d = 1'b1;
    end
    if (wr_mask) begin
      mask_d = REG_WDATA[`RTC_EVT_BIT];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      evt_q  <= 1'b0;
      mask_q <= 1'b0;
    end else begin
      evt_q  <= evt_d;
      mask_q <= mask_d;
    end
  end

  assign RTC_PERIOD_INTERRUPT = evt_q & mask_q;

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Data valid only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_d = '0;
    if (REG_RD) begin
      case (REG_ADDR)
        `RTC_OFS_CONTROL: begin
          // Upper bits undefined to software; driven as zero
          rdata_d[`RTC_RUN_BIT]              = run_q;
          rdata_d[`RTC_SEL_MSB:`RTC_SEL_LSB] = sel_q;
        end
        `RTC_OFS_STATUS: begin
          rdata_d[`RTC_EVT_BIT] = evt_q;
        end
        `RTC_OFS_MASK: begin
          rdata_d[`RTC_EVT_BIT] = mask_q;
        end
        `RTC_OFS_COUNT_LO: begin
          rdata_d = count[7:0];
        end
        `RTC_OFS_COUNT_HI: begin
          rdata_d[`RTC_CNT_W-9:0] = count[`RTC_CNT_W-1:8];
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA = rdata_q;

endmodule : rtc_top

/* File: verif/rtc_top_sva.sv */
// Checker of the real-time counter ports: read slot, run start, shutdown, interrupt.
// Assumes rtc_map.svh and rtc_pkg are compiled first; bound onto rtc_top.
`timescale 1ns/10ps
`include "rtc_map.svh"

module rtc_top_sva (
  input wire logic               SYS_CLK,
  input wire logic               RESET_N,
  input wire rtc_pkg::rtc_addr_t REG_ADDR,
  input wire rtc_pkg::rtc_data_t REG_WDATA,
  input wire logic               REG_WR,
  input wire logic               REG_RD,
  input wire rtc_pkg::rtc_data_t REG_RDATA,
  input wire logic               LF_CLK,
  input wire logic               LF_OSC_ENABLE,
  input wire logic               STOP_MODE,
  input wire logic               DEEP_SLEEP_STATE,
  input wire logic               DEBUG_BREAK,
  input wire logic               RTC_RUNNING,
  input wire logic               RTC_PERIOD_INTERRUPT
);
  import rtc_pkg::*;
  // ------------
  // Properties
  // ------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside read slot");
  a_ctrl_upper_zero: assert property ($past(REG_RD) && $past(REG_ADDR) == `RTC_OFS_CONTROL
    |-> REG_RDATA[7:3] == 5'h00) else $error("control upper bits not zero");
  a_run_start: assert property (REG_WR && REG_ADDR == `RTC_OFS_CONTROL && REG_WDATA[0]
    && LF_OSC_ENABLE && !STOP_MODE && !DEEP_SLEEP_STATE |-> ##2 RTC_RUNNING) else $error("run not started");
  a_osc_off_stop: assert property (!LF_OSC_ENABLE |-> ##2 !RTC_RUNNING)
    else $error("running with oscillator off");
  a_sleep_stop: assert property (STOP_MODE || DEEP_SLEEP_STATE |-> ##2 !RTC_RUNNING)
    else $error("running in stop or deep sleep");
  a_irq_from_run: assert property ($rose(RTC_PERIOD_INTERRUPT) && !$past(REG_WR)
    |-> $past(RTC_RUNNING)) else $error("interrupt without running counter");
  a_status_clear: assert property (REG_WR && REG_ADDR == `RTC_OFS_STATUS && REG_WDATA[0]
    && !RTC_RUNNING |=> !RTC_PERIOD_INTERRUPT) else $error("status not cleared");
  a_mask_gate: assert property (REG_WR && REG_ADDR == `RTC_OFS_MASK && !REG_WDATA[0]
    |=> !RTC_PERIOD_INTERRUPT [*2]) else $error("masked interrupt seen");
  a_break_hold: assert property ($past(RTC_RUNNING) && DEBUG_BREAK && !$past(REG_WR)
    && LF_OSC_ENABLE && !STOP_MODE && !DEEP_SLEEP_STATE |-> RTC_RUNNING) else $error("break stopped run");
endmodule : rtc_top_sva

bind rtc_top rtc_top_sva chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .LF_CLK(LF_CLK),
  .LF_OSC_ENABLE(LF_OSC_ENABLE), .STOP_MODE(STOP_MODE), .DEEP_SLEEP_STATE(DEEP_SLEEP_STATE),
  .DEBUG_BREAK(DEBUG_BREAK), .RTC_RUNNING(RTC_RUNNING), .RTC_PERIOD_INTERRUPT(RTC_PERIOD_INTERRUPT));

/* File: verif/test_low_freq_periodic_rtc.sv */
// Self-checking bench of the real-time counter: registers, periods, break, shutdown.
// Assumes a fast LF_CLK (one tick each 6 cycles) so that periods stay short.
`timescale 1ns/10ps
`include "rtc_map.svh"

module test_low_freq_periodic_rtc;
  import rtc_pkg::*;
  logic      SYS_CLK, RESET_N, REG_WR, REG_RD, LF_CLK, LF_OSC_ENABLE;
  logic      STOP_MODE, DEEP_SLEEP_STATE, DEBUG_BREAK, RTC_RUNNING, RTC_PERIOD_INTERRUPT;
  rtc_addr_t REG_ADDR;
  rtc_data_t REG_WDATA, REG_RDATA, v, w;
  int        n_fail, checked, lf_cnt, n;

  rtc_top dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .LF_CLK(LF_CLK),
    .LF_OSC_ENABLE(LF_OSC_ENABLE), .STOP_MODE(STOP_MODE), .DEEP_SLEEP_STATE(DEEP_SLEEP_STATE),
    .DEBUG_BREAK(DEBUG_BREAK), .RTC_RUNNING(RTC_RUNNING), .RTC_PERIOD_INTERRUPT(RTC_PERIOD_INTERRUPT));

  // ------------
  // Clocks
  // ------------
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // Three cycles high and low keeps above the sync minimum
  always @(posedge SYS_CLK) begin
    if (lf_cnt == 2) begin
      lf_cnt <= 0;
      LF_CLK <= ~LF_CLK;
    end else begin
      lf_cnt <= lf_cnt + 1;
    end
  end

  // ------------
  // Bus and checks
  // ------------
  task wr(input rtc_addr_t a, input rtc_data_t d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
    // Step off the edge so callers see the write's effect, not the old value
    #1;
  endtask : wr
  task rd(input rtc_addr_t a, output rtc_data_t d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask : rd
  task chk(input rtc_data_t got, input rtc_data_t exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rchk(input rtc_addr_t a, input rtc_data_t exp);
    rtc_data_t r;
    rd(a, r);
    chk(r, exp);
  endtask : rchk
  task wait_irq(output int c);
    c = 0;
    while (RTC_PERIOD_INTERRUPT !== 1'b1 && c < 30000) begin
      @(posedge SYS_CLK);
      #1 c++;
    end
  endtask : wait_irq

  // ------------
  // Scenarios
  // ------------
  task t_reset;
    for (int a = 0; a < 8; a++) rchk(rtc_addr_t'(a), 8'h00);
  endtask : t_reset
  task t_period;
    wr(`RTC_OFS_CONTROL, 8'hF6);
    rchk(`RTC_OFS_CONTROL, 8'h06);
    wr(`RTC_OFS_MASK, 8'h01);
    wr(`RTC_OFS_CONTROL, 8'h07);
    wait_irq(n);
    wr(`RTC_OFS_STATUS, 8'h01);
    wait_irq(n);
    chk(rtc_data_t'(n + 2 >= 12286 && n + 2 <= 12290), 8'h01);
    rchk(`RTC_OFS_COUNT_HI, 8'h00);
    wr(`RTC_OFS_MASK, 8'h00);
    chk({7'h00, RTC_PERIOD_INTERRUPT}, 8'h00);
    wr(`RTC_OFS_MASK, 8'h01);
    chk({7'h00, RTC_PERIOD_INTERRUPT}, 8'h01);
  endtask : t_period
  task t_break;
    @(posedge SYS_CLK);
    DEBUG_BREAK <= 1'b1;
    repeat (10) @(posedge SYS_CLK);
    rd(`RTC_OFS_COUNT_LO, v);
    repeat (30) @(posedge SYS_CLK);
    rchk(`RTC_OFS_COUNT_LO, v);
    rchk(`RTC_OFS_CONTROL, 8'h07);
    @(posedge SYS_CLK);
    DEBUG_BREAK <= 1'b0;
    repeat (30) @(posedge SYS_CLK);
    rd(`RTC_OFS_COUNT_LO, w);
    chk(rtc_data_t'(w !== v), 8'h01);
  endtask : t_break
  task t_sel2;
    wr(`RTC_OFS_CONTROL, 8'h06);
    wr(`RTC_OFS_CONTROL, 8'h04);
    wr(`RTC_OFS_STATUS, 8'h01);
    chk({7'h00, RTC_PERIOD_INTERRUPT}, 8'h00);
    wr(`RTC_OFS_CONTROL, 8'h05);
    wait_irq(n);
    chk(rtc_data_t'(n >= 24570 && n <= 24600), 8'h01);
  endtask : t_sel2
  // Longest period is too long to finish; only checks it outlasts the shortest
  task t_sel0;
    wr(`RTC_OFS_CONTROL, 8'h04);
    wr(`RTC_OFS_CONTROL, 8'h00);
    wr(`RTC_OFS_STATUS, 8'h01);
    wr(`RTC_OFS_CONTROL, 8'h01);
    repeat (12600) @(posedge SYS_CLK);
    rchk(`RTC_OFS_STATUS, 8'h00);
    rd(`RTC_OFS_COUNT_HI, v);
    chk(rtc_data_t'(v >= 8'h08), 8'h01);
    wr(`RTC_OFS_CONTROL, 8'h00);
  endtask : t_sel0
  task t_shutdown;
    for (int i = 0; i < 3; i++) begin
      wr(`RTC_OFS_CONTROL, 8'h05);
      repeat (20) @(posedge SYS_CLK);
      chk({7'h00, RTC_RUNNING}, 8'h01);
      LF_OSC_ENABLE <= (i != 0);
      STOP_MODE <= (i == 1);
      DEEP_SLEEP_STATE <= (i == 2);
      repeat (4) @(posedge SYS_CLK);
      #1 chk({7'h00, RTC_RUNNING}, 8'h00);
      @(posedge SYS_CLK);
      LF_OSC_ENABLE <= 1'b1;
      STOP_MODE <= 1'b0;
      DEEP_SLEEP_STATE <= 1'b0;
      rchk(`RTC_OFS_CONTROL, 8'h00);
      rchk(`RTC_OFS_COUNT_LO, 8'h00);
    end
  endtask : t_shutdown

  task wrap_up;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // ------------
  // Sequence
  // ------------
  initial begin
    {RESET_N, REG_WR, REG_RD, LF_CLK, STOP_MODE, DEEP_SLEEP_STATE, DEBUG_BREAK} = 7'h00;
    LF_OSC_ENABLE = 1'b1;
    REG_ADDR = '0;
    REG_WDATA = '0;
    n_fail = 0;
    checked = 0;
    repeat (8) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    t_reset;
    t_period;
    t_break;
    t_sel2;
    t_sel0;
    t_shutdown;
    wrap_up;
  end
  // Runs about three fifths this long when all is well
  initial begin
    repeat (100000) @(posedge SYS_CLK);
    n_fail++;
    wrap_up;
  end
endmodule : test_low_freq_periodic_rtc
